// File: inc/ea_decode_pkg.sv
// constants and types for the effective-address decode and cycle accounting block
package ea_decode_pkg;

	// operand access widths
	typedef enum logic [1:0] {WID_BYTE, WID_WORD, WID_LONG} width_t;

	// operand location classes
	typedef enum logic [2:0] {LOC_REG, LOC_INT_MEM, LOC_EXT16, LOC_EXT8} loc_t;

	// addressing mode classes
	typedef enum logic [2:0] {
		MODE_REG, MODE_IND, MODE_POSTINC, MODE_SHORT_DISPLACEMENT, MODE_LONG_DISPLACEMENT, MODE_INDEX, MODE_PCREL,
		MODE_ABS
	} mode_t;

	// accumulator extension codes
	typedef enum logic [1:0] {LH_NONE, LH_ZERO, LH_SIGN} lhExt_t;
	typedef enum logic [1:0] {AH_NONE, AH_COPY, AH_ZERO, AH_SIGN} ahExt_t;

	// per-flag update codes
	typedef enum logic [1:0] {FLG_KEEP, FLG_RESULT, FLG_SET, FLG_CLEAR} flagOp_t;

	// effective-address code boundaries
	localparam logic [4:0] EA_IND_BASE = 5'h08;
	localparam logic [4:0] EA_POSTINC_BASE = 5'h0C;
	localparam logic [4:0] EA_SHORT_DISPLACEMENT_BASE = 5'h10;
	localparam logic [4:0] EA_LONG_DISPLACEMENT_BASE = 5'h18;
	localparam logic [4:0] EA_INDEX_BASE = 5'h1C;
	localparam logic [4:0] EA_PCREL = 5'h1E;
	localparam logic [4:0] EA_ABS = 5'h1F;
	localparam logic [2:0] INDEX_REG_NUM = 3'h7;

	// addressing overhead cycles and register accesses
	localparam logic [3:0] CYC_POSTINC = 4'h4;
	localparam logic [3:0] CYC_INDEX = 4'h4;
	localparam logic [3:0] CYC_IND = 4'h2;
	localparam logic [3:0] CYC_PCREL = 4'h2;
	localparam logic [3:0] CYC_ABS = 4'h1;
	localparam logic [2:0] ACC_TWO = 3'h2;
	localparam logic [2:0] ACC_ONE = 3'h1;

	// location correction values
	localparam logic [3:0] COR_INT_ODD_WORD = 4'h2;
	localparam logic [3:0] COR_INT_ODD_LONG = 4'h4;
	localparam logic [3:0] COR_EXT_BYTE = 4'h1;
	localparam logic [3:0] COR_EXT16_EVEN_WORD = 4'h1;
	localparam logic [3:0] COR_EXT16_EVEN_LONG = 4'h2;
	localparam logic [3:0] COR_EXT_WORD = 4'h4;
	localparam logic [3:0] COR_EXT_LONG = 4'h8;

	// worst-case program fetch corrections
	localparam logic [3:0] FETCH_INT_WORD = 4'h2;
	localparam logic [3:0] FETCH_EXT = 4'h3;

	// vector field widths
	localparam logic [7:0] SHORT_VECTOR_MASK = 8'h0F;

endpackage

// File: core/ea_decode_and_cycle_accounting.sv
// effective-address decode, cycle accounting and accumulator extension
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: codes 00-07 select register directly, no extension
// RULE2: 08-0B indirect, 0C-0F indirect with post-increment
// RULE3: 10-17 register plus 8-bit displacement, one byte
// RULE4: 18-1B register plus 16-bit displacement, two bytes
// RULE5: 1C/1D index by reg seven; 1E PC; 1F absolute
// RULE6: addressing overhead cycles and register accesses per mode
// RULE7: internal memory odd address word/long penalties
// RULE8: 16-bit external bus even/odd correction values
// RULE9: 8-bit external bus adds 1, 4, 8
// RULE10: external bus adds inserted wait cycles
// RULE11: worst-case program fetch correction per bus
// RULE12: actual cycles equal base plus correction
// RULE13: accumulator view follows access width
// RULE14: byte load sets bits 15..8 per code
// RULE15: upper half copied, zeroed or sign-extended
// RULE16: byte loads move old low half upward
// RULE17: each flag updated, set, cleared or kept
// RULE18: immediate byte sign-extended to sixteen bits
// RULE19: vector number four or eight bits wide
// RULE20: report extension bytes to fetch unit
module ea_decode_and_cycle_accounting
	import ea_decode_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic decodeValid,
	input wire logic [4:0] eaCode,
	input wire width_t opWidth,
	input wire loc_t opLocation,
	input wire logic opAddrOdd,
	input wire logic fetchWordBoundary,
	input wire logic [7:0] baseCycles,
	input wire logic [7:0] extWaitCycles,
	input wire logic [2:0] opcodeBytes,
	input wire logic byteLoad,
	input wire logic [31:0] accIn,
	input wire logic [15:0] loadData,
	input wire lhExt_t lhExtCode,
	input wire ahExt_t ahExtCode,
	input wire logic [6:0] flagsIn,
	input wire logic [6:0] flagsResult,
	input wire logic [13:0] flagOps,
	input wire logic [7:0] immediateByte,
	input wire logic [7:0] vectorField,
	input wire logic vectorLong,
	output logic resultValid,
	output mode_t eaMode,
	output logic [2:0] baseRegNum,
	output logic [1:0] regViewWidth,
	output logic postIncrement,
	output logic useIndexReg,
	output logic [2:0] indexRegNum,
	output logic [1:0] extBytes,
	output logic [3:0] instrLength,
	output logic [3:0] eaCycles,
	output logic [2:0] eaRegAccesses,
	output logic [3:0] corrCycles,
	output logic [2:0] busAccesses,
	output logic [3:0] fetchCorrCycles,
	output logic [9:0] actualCycles,
	output logic [31:0] accOut,
	output logic [31:0] accOperand,
	output logic [6:0] flagsOut,
	output logic [15:0] signExtImm,
	output logic [7:0] vectorNumber
);

	////////////////////////////////////////////////////////////////////////////////
	// state record
	typedef struct packed {
		logic valid;
		mode_t mode;
		logic [2:0] baseReg;
		logic [1:0] view;
		logic postInc;
		logic useIdx;
		logic [1:0] extB;
		logic [3:0] instrLen;
		logic [3:0] cyc;
		logic [2:0] acc;
		logic [3:0] corr;
		logic [2:0] busAcc;
		logic [3:0] fetchCorr;
		logic [9:0] actual;
		logic [31:0] accNew;
		logic [31:0] accView;
		logic [6:0] flags;
		logic [15:0] sxImm;
		logic [7:0] vect;
	} state_t;

	state_t state_reg;
	state_t state_next;

	////////////////////////////////////////////////////////////////////////////////
	// sign-extend a byte to a word
	function automatic logic [15:0] sext8(input logic [7:0] b);
		sext8 = {{8{b[7]}}, b};
	endfunction

	// apply one flag update code
	function automatic logic flagApply(input flagOp_t op, input logic oldV, input logic resV);
		case (op)
			FLG_RESULT: flagApply = resV;
			FLG_SET: flagApply = 1'b1;
			FLG_CLEAR: flagApply = 1'b0;
			default: flagApply = oldV;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// combinational decode of the next state
	always_comb
	begin
		logic [15:0] lowNew;
		logic [15:0] lowOld;
		logic [9:0] sum;
		lowNew = accIn[15:0];
		lowOld = accIn[15:0];
		sum = 10'h000;
		state_next = state_reg;
		state_next.valid = decodeValid;
		state_next.postInc = 1'b0;
		state_next.useIdx = 1'b0;
		state_next.baseReg = eaCode[2:0];
		state_next.view = opWidth;
		state_next.extB = 2'h0;
		state_next.cyc = 4'h0;
		state_next.acc = 3'h0;
		// addressing mode and overhead
		if (eaCode < EA_IND_BASE)
		begin
			state_next.mode = MODE_REG; // [RULE1]
		end
		else if (eaCode < EA_POSTINC_BASE)
		begin
			state_next.mode = MODE_IND; // [RULE2]
			state_next.baseReg = {1'b0, eaCode[1:0]};
			state_next.cyc = CYC_IND; // [RULE6]
			state_next.acc = ACC_ONE;
		end
		else if (eaCode < EA_SHORT_DISPLACEMENT_BASE)
		begin
			state_next.mode = MODE_POSTINC;
			state_next.baseReg = {1'b0, eaCode[1:0]};
			state_next.postInc = 1'b1; // [RULE2]
			state_next.cyc = CYC_POSTINC; // [RULE6]
			state_next.acc = ACC_TWO;
		end
		else if (eaCode < EA_LONG_DISPLACEMENT_BASE)
		begin
			state_next.mode = MODE_SHORT_DISPLACEMENT;
			state_next.extB = 2'h1; // [RULE3]
			state_next.cyc = CYC_IND; // [RULE6]
			state_next.acc = ACC_ONE;
		end
		else if (eaCode < EA_INDEX_BASE)
		begin
			state_next.mode = MODE_LONG_DISPLACEMENT;
			state_next.baseReg = {1'b0, eaCode[1:0]};
			state_next.extB = 2'h2; // [RULE4]
			state_next.cyc = CYC_IND; // [RULE6]
			state_next.acc = ACC_ONE;
		end
		else if (eaCode < EA_PCREL)
		begin
			state_next.mode = MODE_INDEX;
			state_next.baseReg = {2'b00, eaCode[0]};
			state_next.useIdx = 1'b1; // [RULE5]
			state_next.cyc = CYC_INDEX; // [RULE6]
			state_next.acc = ACC_TWO;
		end
		else if (eaCode == EA_PCREL)
		begin
			state_next.mode = MODE_PCREL;
			state_next.extB = 2'h2; // [RULE5]
			state_next.cyc = CYC_PCREL; // [RULE6]
		end
		else
		begin
			state_next.mode = MODE_ABS;
			state_next.extB = 2'h2; // [RULE5]
			state_next.cyc = CYC_ABS; // [RULE6]
		end
		// instruction length for the fetch unit
		state_next.instrLen = 4'(opcodeBytes) + 4'(state_next.extB); // [RULE20]
		// location correction and bus accesses
		state_next.corr = 4'h0;
		case (opWidth)
			WID_WORD: state_next.busAcc = 3'h1;
			WID_LONG: state_next.busAcc = 3'h2;
			default: state_next.busAcc = 3'h1;
		endcase
		case (opLocation)
			LOC_INT_MEM:
			begin
				if (opAddrOdd && opWidth == WID_WORD)
				begin
					state_next.corr = COR_INT_ODD_WORD; // [RULE7]
					state_next.busAcc = 3'h2;
				end
				else if (opAddrOdd && opWidth == WID_LONG)
				begin
					state_next.corr = COR_INT_ODD_LONG; // [RULE7]
					state_next.busAcc = 3'h4;
				end
			end
			LOC_EXT16:
			begin
				case (opWidth)
					WID_WORD:
					begin
						state_next.corr = opAddrOdd ? COR_EXT_WORD : COR_EXT16_EVEN_WORD; // [RULE8]
						state_next.busAcc = opAddrOdd ? 3'h2 : 3'h1;
					end
					WID_LONG:
					begin
						state_next.corr = opAddrOdd ? COR_EXT_LONG : COR_EXT16_EVEN_LONG; // [RULE8]
						state_next.busAcc = opAddrOdd ? 3'h4 : 3'h2;
					end
					default: state_next.corr = COR_EXT_BYTE; // [RULE8]
				endcase
			end
			LOC_EXT8:
			begin
				case (opWidth)
					WID_WORD:
					begin
						state_next.corr = COR_EXT_WORD; // [RULE9]
						state_next.busAcc = 3'h2;
					end
					WID_LONG:
					begin
						state_next.corr = COR_EXT_LONG; // [RULE9]
						state_next.busAcc = 3'h4;
					end
					default: state_next.corr = COR_EXT_BYTE; // [RULE9]
				endcase
			end
			default: state_next.corr = 4'h0; // [RULE7]
		endcase
		// worst-case fetch correction
		case (opLocation)
			LOC_INT_MEM: state_next.fetchCorr = fetchWordBoundary ? FETCH_INT_WORD : 4'h0;
			LOC_EXT16: state_next.fetchCorr = fetchWordBoundary ? FETCH_EXT : 4'h0; // [RULE11]
			LOC_EXT8: state_next.fetchCorr = fetchWordBoundary ? 4'h0 : FETCH_EXT; // [RULE11]
			default: state_next.fetchCorr = 4'h0;
		endcase
		// total actual cycles including external waits
		sum = 10'(baseCycles) + 10'(state_next.corr); // [RULE12]
		if (opLocation == LOC_EXT16 || opLocation == LOC_EXT8)
		begin
			sum = sum + 10'(extWaitCycles); // [RULE10]
		end
		state_next.actual = sum;
		// accumulator view by width
		case (opWidth)
			WID_BYTE: state_next.accView = {24'h000000, accIn[7:0]}; // [RULE13]
			WID_WORD: state_next.accView = {16'h0000, accIn[15:0]}; // [RULE13]
			default: state_next.accView = accIn; // [RULE13]
		endcase
		// low half update for loads
		if (byteLoad)
		begin
			case (lhExtCode)
				LH_ZERO: lowNew = {8'h00, loadData[7:0]}; // [RULE14] [RULE16]
				LH_SIGN: lowNew = sext8(loadData[7:0]); // [RULE14] [RULE16]
				default: lowNew = {accIn[15:8], loadData[7:0]}; // [RULE14]
			endcase
		end
		else if (opWidth == WID_WORD)
		begin
			lowNew = loadData;
		end
		// upper half update
		case (ahExtCode)
			AH_COPY: state_next.accNew = {lowOld, lowNew}; // [RULE15] [RULE16]
			AH_ZERO: state_next.accNew = {16'h0000, lowNew}; // [RULE15]
			AH_SIGN: state_next.accNew = {{16{lowNew[15]}}, lowNew}; // [RULE15]
			default: state_next.accNew = {accIn[31:16], lowNew};
		endcase
		// flag updates, bit 6 interrupt enable down to bit 0 carry
		for (int i = 0; i < 7; i++)
		begin
			state_next.flags[i] = flagApply(flagOp_t'(flagOps[2*i +: 2]), flagsIn[i],
				flagsResult[i]); // [RULE17]
		end
		// immediate and vector operands
		state_next.sxImm = sext8(immediateByte); // [RULE18]
		state_next.vect = vectorLong ? vectorField : (vectorField & SHORT_VECTOR_MASK); // [RULE19]
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state record, except indexRegNum tied to INDEX_REG_NUM
	assign resultValid = state_reg.valid;
	assign eaMode = state_reg.mode;
	assign baseRegNum = state_reg.baseReg;
	assign regViewWidth = state_reg.view;
	assign postIncrement = state_reg.postInc;
	assign useIndexReg = state_reg.useIdx;
	assign indexRegNum = INDEX_REG_NUM;
	assign extBytes = state_reg.extB;
	assign instrLength = state_reg.instrLen;
	assign eaCycles = state_reg.cyc;
	assign eaRegAccesses = state_reg.acc;
	assign corrCycles = state_reg.corr;
	assign busAccesses = state_reg.busAcc;
	assign fetchCorrCycles = state_reg.fetchCorr;
	assign actualCycles = state_reg.actual;
	assign accOut = state_reg.accNew;
	assign accOperand = state_reg.accView;
	assign flagsOut = state_reg.flags;
	assign signExtImm = state_reg.sxImm;
	assign vectorNumber = state_reg.vect;

endmodule

`default_nettype wire

// File: verif/ea_decode_asserts.sv
// concurrent checks on the decode block ports
`timescale 1ns/1ps
`default_nettype none

module ea_decode_asserts
	import ea_decode_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [4:0] eaCode,
	input wire width_t opWidth,
	input wire loc_t opLocation,
	input wire logic opAddrOdd,
	input wire logic [7:0] baseCycles,
	input wire logic [7:0] extWaitCycles,
	input wire logic [2:0] opcodeBytes,
	input wire logic [7:0] immediateByte,
	input wire logic vectorLong,
	input wire mode_t eaMode,
	input wire logic [2:0] baseRegNum,
	input wire logic [1:0] regViewWidth,
	input wire logic [2:0] indexRegNum,
	input wire logic postIncrement,
	input wire logic useIndexReg,
	input wire logic [1:0] extBytes,
	input wire logic [3:0] instrLength,
	input wire logic [3:0] eaCycles,
	input wire logic [2:0] eaRegAccesses,
	input wire logic [3:0] corrCycles,
	input wire logic [9:0] actualCycles,
	input wire logic [15:0] signExtImm,
	input wire logic [7:0] vectorNumber
);

default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!reset_n);

////////////////////////////////////////////////////////////////////////
// mode decode one cycle after the code is taken
property p_reg;
	eaCode < 5'h08 |=> eaMode == MODE_REG && extBytes == 2'h0;
endproperty
a_reg: assert property (p_reg) else $error("register direct decode wrong");
property p_postinc;
	eaCode[4:2] == 3'h3 |=> postIncrement && eaCycles == 4'h4 && eaRegAccesses == 3'h2;
endproperty
a_postinc: assert property (p_postinc) else $error("post increment decode wrong");
property p_short_displacement;
	eaCode[4:3] == 2'h2 |=> eaMode == MODE_SHORT_DISPLACEMENT && extBytes == 2'h1;
endproperty
a_short_displacement: assert property (p_short_displacement) else $error("short displacement decode wrong");
property p_long_displacement;
	eaCode[4:2] == 3'h6 |=> extBytes == 2'h2 && eaCycles == 4'h2 && eaRegAccesses == 3'h1;
endproperty
a_long_displacement: assert property (p_long_displacement) else $error("long displacement decode wrong");
property p_index;
	eaCode == 5'h1D |=> useIndexReg && baseRegNum == 3'h1 && eaCycles == 4'h4;
endproperty
a_index: assert property (p_index) else $error("indexed decode wrong");
property p_abs;
	eaCode == 5'h1F |=> eaMode == MODE_ABS && eaCycles == 4'h1 && eaRegAccesses == 3'h0;
endproperty
a_abs: assert property (p_abs) else $error("direct address decode wrong");
property p_base;
	eaCode[4:2] == 3'h2 |=> baseRegNum == {1'b0, $past(eaCode[1:0])};
endproperty
a_base: assert property (p_base) else $error("indirect base register wrong");
property p_view;
	1'b1 |=> regViewWidth == $past(opWidth) && indexRegNum == 3'h7;
endproperty
a_view: assert property (p_view) else $error("register view or index number wrong");

////////////////////////////////////////////////////////////////////////
// counts and conversions tied to the inputs one cycle back
property p_len;
	1'b1 |=> instrLength == $past(opcodeBytes) + extBytes;
endproperty
a_len: assert property (p_len) else $error("instruction length wrong");
property p_actual;
	1'b1 |=> actualCycles == $past(baseCycles) + corrCycles
		+ ($past(opLocation) >= LOC_EXT16 ? $past(extWaitCycles) : 8'h00);
endproperty
a_actual: assert property (p_actual) else $error("actual cycle count wrong");
property p_intEven;
	opLocation == LOC_INT_MEM && !opAddrOdd |=> corrCycles == 4'h0;
endproperty
a_intEven: assert property (p_intEven) else $error("even internal penalty");
property p_simm;
	1'b1 |=> signExtImm == {{8{$past(immediateByte[7])}}, $past(immediateByte)};
endproperty
a_simm: assert property (p_simm) else $error("immediate extension wrong");
property p_vec;
	!vectorLong |=> vectorNumber[7:4] == 4'h0;
endproperty
a_vec: assert property (p_vec) else $error("short vector too wide");

// main scenarios reached
c_postinc: cover property (eaCode == 5'h0C ##1 corrCycles == 4'h4);
c_ext8: cover property (opLocation == LOC_EXT8 ##1 corrCycles == 4'h8);
c_pcrel: cover property (eaCode == 5'h1E ##1 eaMode == MODE_PCREL);

endmodule

bind ea_decode_and_cycle_accounting ea_decode_asserts i_ea_decode_asserts (.clk_sys, .reset_n,
	.eaCode, .opWidth, .opLocation, .opAddrOdd, .baseCycles, .extWaitCycles, .opcodeBytes,
	.immediateByte, .vectorLong, .eaMode, .baseRegNum, .regViewWidth, .indexRegNum,
	.postIncrement, .useIndexReg,
	.extBytes, .instrLength, .eaCycles, .eaRegAccesses, .corrCycles, .actualCycles,
	.signExtImm, .vectorNumber);

`default_nettype wire

// File: verif/ready_wait_model.sv
// pipeline side model of external bus ready wait insertion
`timescale 1ns/1ps
`default_nettype none

module ready_wait_model
(
	input wire logic clk_sys,
	input wire logic slow,
	output var logic [7:0] extWaitCycles
);

int s = 32;

// new wait count each cycle, short or long; junk when bus unused
always @(posedge clk_sys)
begin
	#1 extWaitCycles = slow ? 8'($random(s)) : 8'($random(s) & 3);
end

endmodule

`default_nettype wire

// File: verif/tb_ea_decode_and_cycle_accounting.sv
// self-checking bench for the decode and cycle accounting block
`timescale 1ns/1ps
`default_nettype none

module tb_ea_decode_and_cycle_accounting
	import ea_decode_pkg::*;
;

logic clk_sys = 0, reset_n = 0, decodeValid = 0, slow = 0;
logic opAddrOdd, fetchWordBoundary, byteLoad, vectorLong, resultValid, postIncrement, useIndexReg;
logic [4:0] eaCode;
width_t opWidth;
loc_t opLocation;
mode_t eaMode;
lhExt_t lhExtCode;
ahExt_t ahExtCode;
logic [7:0] baseCycles, immediateByte, vectorField, vectorNumber;
wire logic [7:0] extWaitCycles;
logic [2:0] opcodeBytes, eaRegAccesses, busAccesses, baseRegNum, indexRegNum;
logic [31:0] accIn, accOut, accOperand;
logic [15:0] loadData, signExtImm;
logic [6:0] flagsIn, flagsResult, flagsOut;
logic [13:0] flagOps;
logic [1:0] extBytes, regViewWidth;
logic [3:0] instrLength, eaCycles, corrCycles, fetchCorrCycles;
logic [9:0] actualCycles;
logic [141:0] q[$], want;
int seed = 32, num_errors = 0, compares = 0;

always #10 clk_sys = ~clk_sys;

ea_decode_and_cycle_accounting i_ea_decode_and_cycle_accounting (.clk_sys, .reset_n,
	.decodeValid, .eaCode, .opWidth, .opLocation, .opAddrOdd, .fetchWordBoundary,
	.baseCycles, .extWaitCycles, .opcodeBytes, .byteLoad, .accIn, .loadData, .lhExtCode,
	.ahExtCode, .flagsIn, .flagsResult, .flagOps, .immediateByte, .vectorField,
	.vectorLong, .resultValid, .eaMode, .baseRegNum, .regViewWidth, .postIncrement,
	.useIndexReg, .indexRegNum, .extBytes, .instrLength, .eaCycles, .eaRegAccesses,
	.corrCycles, .busAccesses, .fetchCorrCycles, .actualCycles, .accOut, .accOperand,
	.flagsOut, .signExtImm, .vectorNumber);

ready_wait_model i_ready_wait_model (.clk_sys, .slow, .extWaitCycles);

////////////////////////////////////////////////////////////////////////
// compare, report and finish
task automatic check(input logic [141:0] seen, input logic [141:0] exp);
	compares++;
	if (seen !== exp)
	begin
		num_errors++;
		$display("FAIL %0t seen %h exp %h", $time, seen, exp);
	end
endtask

task automatic end_of_test();
	if (num_errors == 0 && compares > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask

// expected outputs worked out from the current inputs
function automatic logic [141:0] model();
	int cycT[8] = '{0, 2, 4, 2, 2, 4, 2, 1};
	int accT[8] = '{0, 1, 2, 1, 1, 2, 0, 0};
	int extT[8] = '{0, 0, 0, 1, 2, 0, 2, 2};
	int m, w, cor, ba, fc;
	logic odd;
	logic [15:0] lo, hi;
	logic [31:0] opv;
	logic [6:0] fl;
	m = eaCode < 8 ? 0 : eaCode < 12 ? 1 : eaCode < 16 ? 2 : eaCode < 24 ? 3 :
		eaCode < 28 ? 4 : eaCode < 30 ? 5 : eaCode == 30 ? 6 : 7;
	w = opWidth;
	odd = opAddrOdd && w != 0;
	ba = (opLocation == LOC_EXT8 || (odd && opLocation != LOC_REG)) ? 1 << w : (w == 2) + 1;
	cor = 0;
	if (opLocation == LOC_EXT8 || (odd && opLocation == LOC_EXT16))
		cor = (w == 0) ? 1 : 4 * w;
	else if (opLocation == LOC_EXT16)
		cor = (w == 2) ? 2 : 1;
	else if (odd && opLocation == LOC_INT_MEM)
		cor = 2 * w;
	fc = fetchWordBoundary ? (opLocation == LOC_INT_MEM ? 2 : opLocation == LOC_EXT16 ? 3 : 0)
		: (opLocation == LOC_EXT8 ? 3 : 0);
	lo = !byteLoad ? (w == 1 ? loadData : accIn[15:0]) : lhExtCode == LH_ZERO ?
		{8'h00, loadData[7:0]} : lhExtCode == LH_SIGN ? 16'(signed'(loadData[7:0])) :
		{accIn[15:8], loadData[7:0]};
	hi = ahExtCode == AH_COPY ? accIn[15:0] : ahExtCode == AH_ZERO ? 16'h0000 :
		ahExtCode == AH_SIGN ? {16{lo[15]}} : accIn[31:16];
	opv = w == 0 ? {24'h0, accIn[7:0]} : w == 1 ? {16'h0, accIn[15:0]} : accIn;
	for (int i = 0; i < 7; i++)
		fl[i] = flagOps[2*i+:2] == FLG_KEEP ? flagsIn[i] : flagOps[2*i+:2] == FLG_RESULT ?
			flagsResult[i] : flagOps[2*i+:2] == FLG_SET;
	return {3'(m), 2'(extT[m]), 4'(cycT[m]), 3'(accT[m]),
		3'(m == 1 || m == 2 || m == 4 ? eaCode[1:0] : m == 5 ? eaCode[0] : eaCode[2:0]),
		2'(w), m == 2, m == 5, 3'h7, 4'(opcodeBytes + extT[m]),
		4'(cor), 3'(ba), 4'(fc),
		10'(baseCycles + cor + (opLocation >= LOC_EXT16 ? extWaitCycles : 0)),
		hi, lo, opv, fl, vectorLong ? vectorField : {4'h0, vectorField[3:0]},
		{{8{immediateByte[7]}}, immediateByte}};
endfunction

// random fields, with a full sweep of code, width, location and parity first
task automatic drive(input int i);
	accIn = $random(seed);
	{loadData, baseCycles, immediateByte} = 32'($random(seed));
	{flagsIn, flagsResult, flagOps} = 28'($random(seed));
	{vectorField, opcodeBytes, fetchWordBoundary, byteLoad, vectorLong, opAddrOdd} =
		15'($random(seed));
	eaCode = 5'($random(seed));
	opWidth = width_t'($unsigned($random(seed)) % 3);
	opLocation = loc_t'($unsigned($random(seed)) % 4);
	lhExtCode = lhExt_t'($unsigned($random(seed)) % 3);
	ahExtCode = ahExt_t'(2'($random(seed)));
	if (i < 768)
	begin
		eaCode = 5'(i);
		opWidth = width_t'((i / 32) % 3);
		opLocation = loc_t'((i / 96) % 4);
		opAddrOdd = i >= 384;
	end
	slow = i > 1500;
	decodeValid = 1;
endtask

////////////////////////////////////////////////////////////////////////
// result watcher takes the oldest note for every valid result
always @(negedge clk_sys)
	if (resultValid === 1'b1)
	begin
		want = q.size() ? q.pop_front() : 'x;
		check(142'({eaMode, extBytes, eaCycles, eaRegAccesses, baseRegNum, regViewWidth,
			postIncrement, useIndexReg, indexRegNum, instrLength}),
			142'(want[141:116]));
		check(142'({corrCycles, busAccesses, fetchCorrCycles, actualCycles}),
			142'(want[115:95]));
		check(142'({accOut, accOperand, flagsOut, vectorNumber, signExtImm}),
			142'(want[94:0]));
	end

// reset, stimulus and drain
initial
begin
	drive(0);
	decodeValid = 0;
	repeat (6) @(posedge clk_sys);
	#1 reset_n = 1;
	for (int i = 0; i < 3000; i++)
	begin
		@(posedge clk_sys);
		#1 drive(i);
		#1 q.push_back(model());
	end
	@(posedge clk_sys);
	#1 decodeValid = 0;
	repeat (3) @(negedge clk_sys);
	check(142'(q.size()), 142'h0);
	// reset after the drain clears the registered outputs at once
	@(posedge clk_sys);
	#1 reset_n = 0;
	#1 check(142'({resultValid, eaMode, accOut, actualCycles, flagsOut}), 142'h0);
	end_of_test();
end

// hang guard
initial
begin
	#200000;
	num_errors++;
	end_of_test();
end

endmodule

`default_nettype wire
